//--- logic/adcseq_pkg.sv
// Package: constants for the conversion sequencer
package adcseq_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_RES_HI = 8'h08;
  localparam logic [7:0] ADDR_RES_LO = 8'h0C;
  localparam logic [7:0] ADDR_PORT = 8'h10;
  localparam logic [7:0] ADDR_DIR = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int A_ON_BIT = 0;
  localparam int A_GO_BIT = 2;
  localparam int A_CHAN_LSB = 3;
  localparam int A_CS_LSB = 6;
  localparam int B_FMT_BIT = 7;
  localparam int B_IE_BIT = 6;
  localparam int B_SLEEP_BIT = 5;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_WAKE_BIT = 1;
  localparam int ST_ACT_BIT = 2;
  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam int CONV_BITS = 12;
  localparam int RECOVER_BITS = 2;
  localparam int INSTR_CYCLE_CLKS = 4;
  localparam logic [5:0] DIV_CODE0 = 6'h02;
  localparam logic [5:0] DIV_CODE1 = 6'h08;
  localparam logic [5:0] DIV_CODE2 = 6'h20;
  localparam logic [1:0] CS_RC = 2'h3;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_CONV, ST_RECOVER} adcsq_state_e;
endpackage

//--- logic/adcseq_top.sv
// Conversion sequencer with AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module adcseq_top
  import adcseq_pkg::*;
#(
  parameter int NPINS = 8
) (
  // AHB-Lite bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Device context
  input wire logic sleep_req,
  input wire logic rc_tick,
  input wire logic [7:0] analog_mask,
  input wire logic [9:0] sample_value,
  input wire logic [NPINS-1:0] pin_in,
  // Analog side
  output logic sample_hold,
  output logic [2:0] channel_select,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe_n,
  output logic wake,
  output logic conversion_done_flag
);
  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  logic [NPINS-1:0] port_latch;
  logic [NPINS-1:0] pin_direction;
  logic [NPINS-1:0] pin_s1;
  logic [NPINS-1:0] pin_s2;
  logic sleep_s1, sleep_s2, rc_s1, rc_s2, rc_d;
  logic powered_down;
  adcsq_state_e state;
  logic [5:0] div_cnt;
  logic [3:0] bit_cnt;
  logic [1:0] instr_cnt;
  logic bit_tick;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic abort_now, finish_now;
  logic [15:0] next_result;

  // Bus address phase decode
  logic addr_ok;
  assign addr_ok = hsel && hready && htrans[1];

  // Justify a 10-bit result into the pair
  function automatic logic [15:0] justify(input logic [9:0] v, input logic right);
    if (right) begin
      justify = {6'h00, v};
    end else begin
      justify = {v, 6'h00};
    end
  endfunction

  // Bit period length for a clock select code
  function automatic logic [5:0] bit_len(input logic [1:0] cs);
    unique case (cs)
      2'h0: bit_len = DIV_CODE0;
      2'h1: bit_len = DIV_CODE1;
      default: bit_len = DIV_CODE2;
    endcase
  endfunction

  // Input synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      sleep_s1 <= 1'b0;
      sleep_s2 <= 1'b0;
      rc_s1 <= 1'b0;
      rc_s2 <= 1'b0;
      rc_d <= 1'b0;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      sleep_s1 <= sleep_req;
      sleep_s2 <= sleep_s1;
      rc_s1 <= rc_tick;
      rc_s2 <= rc_s1;
      rc_d <= rc_s2;
    end
  end

  // Bit period tick: divider or RC edge (RC runs in sleep)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 6'h00;
    end else if (state == ST_IDLE || abort_now || // Abort restarts it: full recovery periods on the divided clock
        div_cnt == bit_len(ctrl_a[A_CS_LSB+:2]) - 6'h01) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end
  always_comb begin
    if (ctrl_a[A_CS_LSB+:2] == CS_RC) begin
      bit_tick = rc_s2 && !rc_d;
    end else begin
      bit_tick = (state != ST_IDLE) && (div_cnt == bit_len(ctrl_a[A_CS_LSB+:2]) - 6'h01);
    end
  end

  // Events of the sequence
  assign abort_now = (state == ST_START || state == ST_CONV) &&
    ((wr_pend && wr_addr == ADDR_CTRL_A && !hwdata[A_GO_BIT]) ||
     (sleep_s2 && ctrl_a[A_CS_LSB+:2] != CS_RC));
  assign finish_now = state == ST_CONV && bit_tick && bit_cnt == 4'(CONV_BITS - 1);
  assign next_result = justify(sample_value, ctrl_b[B_FMT_BIT]);

  // Sequencer; channel and direction bits do not gate it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      instr_cnt <= 2'h0;
    end else if (abort_now) begin
      state <= ST_RECOVER;
      bit_cnt <= 4'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // Go bit is the request: a go written during recovery waits here
          if (ctrl_a[A_GO_BIT] && ctrl_a[A_ON_BIT] && !powered_down) begin
            state <= ST_START;
            instr_cnt <= 2'h0;
          end
        end
        ST_START: begin
          // RC clock: one instruction cycle, then conversion; divided clock: ends at first bit period
          instr_cnt <= instr_cnt + 2'h1;
          if ((ctrl_a[A_CS_LSB+:2] == CS_RC &&
               instr_cnt == 2'(INSTR_CYCLE_CLKS - 1)) ||
              (ctrl_a[A_CS_LSB+:2] != CS_RC && bit_tick)) begin
            state <= ST_CONV;
            bit_cnt <= 4'h0;
          end
        end
        ST_CONV: begin
          if (bit_tick) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (finish_now) begin
              state <= ST_RECOVER;
              bit_cnt <= 4'h0;
            end
          end
        end
        ST_RECOVER: begin
          if (bit_tick) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == 4'(RECOVER_BITS - 1)) begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Internal power-down while the on bit stays set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      powered_down <= 1'b0;
    end else if (abort_now && sleep_s2) begin
      powered_down <= 1'b1;
    end else if (finish_now && sleep_s2 && !ctrl_b[B_IE_BIT]) begin
      powered_down <= 1'b1;
    end else if (!sleep_s2 || (wr_pend && wr_addr == ADDR_CTRL_A)) begin
      powered_down <= 1'b0;
    end
  end

  // Wake pulse on completion in sleep with interrupt enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake <= 1'b0;
    end else begin
      wake <= finish_now && sleep_s2 && ctrl_b[B_IE_BIT];
    end
  end

  // Control register A; hardware clear of go on completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_a <= CTRL_A_RST;
    end else if (wr_pend && wr_addr == ADDR_CTRL_A) begin
      ctrl_a <= {hwdata[7:3], hwdata[A_GO_BIT] & ctrl_a[A_ON_BIT], 1'b0, hwdata[0]};
    end else if (finish_now || abort_now) begin
      ctrl_a[A_GO_BIT] <= 1'b0;
    end
  end

  // Control register B
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_b <= CTRL_B_RST;
    end else if (wr_pend && wr_addr == ADDR_CTRL_B) begin
      ctrl_b <= {hwdata[7:6], 6'h00};
    end
  end

  // Done flag: set wins over software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conversion_done_flag <= 1'b0;
    end else if (finish_now) begin
      conversion_done_flag <= 1'b1;
    end else if (wr_pend && wr_addr == ADDR_STATUS && hwdata[ST_DONE_BIT]) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // Result pair: no reset, storage while converter is off
  always_ff @(posedge hclk) begin
    if (finish_now) begin
      {res_hi, res_lo} <= next_result;
    end else if (wr_pend && wr_addr == ADDR_RES_HI && !ctrl_a[A_ON_BIT]) begin
      res_hi <= hwdata[7:0];
    end else if (wr_pend && wr_addr == ADDR_RES_LO && !ctrl_a[A_ON_BIT]) begin
      res_lo <= hwdata[7:0];
    end
  end

  // Port latch and direction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_latch <= '0;
      pin_direction <= NPINS'(DIR_RST);
    end else if (wr_pend && wr_addr == ADDR_PORT) begin
      port_latch <= hwdata[NPINS-1:0];
    end else if (wr_pend && wr_addr == ADDR_DIR) begin
      pin_direction <= hwdata[NPINS-1:0];
    end
  end

  // Pin drivers: output pin's level reaches the converter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= '0;
      pin_oe_n <= '1;
      sample_hold <= 1'b0;
      channel_select <= 3'h0;
    end else begin
      pin_out <= port_latch;
      pin_oe_n <= pin_direction;
      sample_hold <= state == ST_START || state == ST_CONV;
      channel_select <= ctrl_a[A_CHAN_LSB+:3];
    end
  end

  // Bus data phase tracking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Read data; analog pins read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      if (addr_ok && !hwrite) begin
        unique case (haddr[7:0])
          ADDR_CTRL_A: hrdata <= {24'h000000, ctrl_a};
          ADDR_CTRL_B: hrdata <= {24'h000000, ctrl_b};
          ADDR_RES_HI: hrdata <= {24'h000000, res_hi};
          ADDR_RES_LO: hrdata <= {24'h000000, res_lo};
          ADDR_PORT: hrdata <= 32'(pin_s2 & ~analog_mask[NPINS-1:0]);
          ADDR_DIR: hrdata <= 32'(pin_direction);
          ADDR_STATUS: hrdata <= {29'h0, state != ST_IDLE, powered_down,
            conversion_done_flag};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

//--- sim/adcseq_chan.sv
// Model of the analog input channels and pin levels
`timescale 1ns/1ps
module adcseq_chan #(
  parameter logic [7:0] PAT = 8'hA5
) (
  // Sequencer side
  input wire logic [2:0] channel_select,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe_n,
  // Converter and pin levels
  output logic [9:0] sample_value,
  output logic [7:0] pin_in
);
  // Driven pins show their own level, others a fixed input pattern
  assign pin_in = (pin_out & ~pin_oe_n) | (PAT & pin_oe_n);
  // Output pin converts its digital level, else a per-channel level
  always_comb begin
    if (!pin_oe_n[channel_select]) begin
      sample_value = pin_out[channel_select] ? 10'h3FF : 10'h000;
    end else begin
      sample_value = {channel_select, 7'h2B};
    end
  end
endmodule

//--- sim/adcseq_sva.sv
// Checker of the sequencer port behaviour
`timescale 1ns/1ps
module adcseq_sva
  import adcseq_pkg::*;
(
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Converter
  input wire logic [7:0] analog_mask,
  input wire logic sample_hold,
  input wire logic wake,
  input wire logic conversion_done_flag
);
  logic rd_q;
  logic [7:0] adr_q;
  logic [9:0] run;
  // Read data phase and length of the last hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      adr_q <= 8'h00;
      run <= 10'h000;
    end else begin
      rd_q <= hsel & hready & htrans[1] & !hwrite;
      adr_q <= haddr[7:0];
      if (sample_hold && !$past(sample_hold)) run <= 10'h001;
      else if (sample_hold && run != 10'h3FF) run <= run + 10'h001;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence low4;
    !sample_hold [*4];
  endsequence
  bus_ready_a: assert property (hreadyout) else $error("hreadyout low");
  bus_okay_a: assert property (!hresp) else $error("hresp not okay");
  rdata_idle_a: assert property (!rd_q |-> hrdata == 32'h0) else $error("hrdata not zero");
  port_analog_a: assert property (rd_q && adr_q == ADDR_PORT |->
    (hrdata[7:0] & analog_mask) == 8'h00) else $error("analog pin read not zero");
  wake_pulse_a: assert property (wake |=> !wake) else $error("wake longer than one cycle");
  wake_flag_a: assert property (wake |-> ##[0:2] conversion_done_flag)
    else $error("wake without done flag");
  conv_len_a: assert property ($rose(conversion_done_flag) |-> run >= 10'h018)
    else $error("conversion too short");
  recover_gap_a: assert property ($fell(sample_hold) |-> low4)
    else $error("hold restarted too early");
endmodule
bind adcseq_top adcseq_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .analog_mask, .sample_hold, .wake, .conversion_done_flag);

//--- sim/tb_top.sv
// Top testbench of the conversion sequencer
`timescale 1ns/1ps
module tb_top;
  import adcseq_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sleep_req, rc_tick;
  logic sample_hold, wake, conversion_done_flag;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize, channel_select;
  logic [7:0] analog_mask, pin_in, pin_out, pin_oe_n;
  logic [9:0] sample_value;
  logic [15:0] r;
  int err_total, total_checks, cyc, wakes, n, w;
  int lo[4] = '{24, 96, 384, 100};
  int hi[4] = '{44, 130, 500, 170};
  // Design and channel model
  adcseq_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .sleep_req, .rc_tick, .analog_mask, .sample_value, .pin_in,
    .sample_hold, .channel_select, .pin_out, .pin_oe_n, .wake, .conversion_done_flag);
  adcseq_chan u_chan (.channel_select, .pin_out, .pin_oe_n, .sample_value, .pin_in);
  assign hready = hreadyout;
  // Bus clock and free running RC clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    rc_tick = 1'b0;
    forever #230 rc_tick = ~rc_tick;
  end
  // Cycle limit and wake pulse count
  always @(posedge hclk) begin
    cyc++;
    if (wake === 1'b1) wakes++;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One single transfer, address phase then data phase
  task automatic bus(input logic [7:0] a, input logic wn, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h000000, a};
    hwrite <= wn;
    htrans <= 2'h2;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(nm, e, q);
  endtask
  // Format and enables, switch on, then set go
  task automatic go(input logic [7:0] b, input logic [7:0] a);
    wr(ADDR_CTRL_B, {24'h000000, b});
    wr(ADDR_CTRL_A, {24'h000000, a});
    wr(ADDR_CTRL_A, {24'h000000, a | 8'h04});
  endtask
  task automatic wait_done();
    n = 0;
    while (conversion_done_flag !== 1'b1 && n < 1000) begin
      @(posedge hclk);
      #1;
      n++;
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge hclk);
  endtask
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    sleep_req = 1'b0;
    analog_mask = 8'h0F;
    idle(12);
    hresetn <= 1'b1;
    rd("ctrl_a", ADDR_CTRL_A, {24'h000000, CTRL_A_RST});
    rd("ctrl_b", ADDR_CTRL_B, {24'h000000, CTRL_B_RST});
    rd("dir", ADDR_DIR, {24'h000000, DIR_RST});
    rd("unmapped", 8'h1C, 32'h0);
    wr(ADDR_RES_HI, 32'h5A);
    wr(ADDR_RES_LO, 32'hC3);
    rd("res_hi", ADDR_RES_HI, 32'h5A);
    rd("res_lo", ADDR_RES_LO, 32'hC3);
    rd("port", ADDR_PORT, 32'hA0);
    // Every clock select code, both result formats
    for (int c = 0; c < 4; c++) begin
      go({c[0], 7'h00}, {c[1:0], c[2:0], 3'h1});
      wait_done();
      total_checks++;
      if (n < lo[c] || n > hi[c]) begin
        err_total++;
        $display("[ERR] conv_len expected %0d to %0d seen %0d", lo[c], hi[c], n);
      end
      r = c[0] ? {6'h00, c[2:0], 7'h2B} : {c[2:0], 7'h2B, 6'h00};
      rd("go_clear", ADDR_CTRL_A, {24'h000000, c[1:0], c[2:0], 3'h1});
      rd("res_hi", ADDR_RES_HI, {24'h000000, r[15:8]});
      rd("res_lo", ADDR_RES_LO, {24'h000000, r[7:0]});
      wr(ADDR_STATUS, 32'h1);
      wr(ADDR_CTRL_A, 32'h0);
    end
    // Abort keeps the earlier result
    wr(ADDR_RES_HI, 32'h12);
    wr(ADDR_RES_LO, 32'h34);
    go(8'h00, 8'h49);
    idle(30);
    wr(ADDR_CTRL_A, 32'h49);
    idle(300);
    chk("abort_flag", 32'h0, {31'h0, conversion_done_flag});
    rd("abort_hi", ADDR_RES_HI, 32'h12);
    rd("abort_lo", ADDR_RES_LO, 32'h34);
    // Output pin converts its own level
    wr(ADDR_CTRL_A, 32'h0);
    wr(ADDR_DIR, 32'hFE);
    wr(ADDR_PORT, 32'h01);
    go(8'h80, 8'h01);
    wait_done();
    rd("drv_hi", ADDR_RES_HI, 32'h03);
    rd("drv_lo", ADDR_RES_LO, 32'hFF);
    wr(ADDR_STATUS, 32'h1);
    // Sleep on the divided clock aborts and powers down
    go(8'h00, 8'h41);
    idle(20);
    sleep_req <= 1'b1;
    idle(300);
    chk("sleep_flag", 32'h0, {31'h0, conversion_done_flag});
    bus(ADDR_STATUS, 1'b0, 32'h0);
    chk("sleep_off", 32'h2, q & 32'h2);
    bus(ADDR_CTRL_A, 1'b0, 32'h0);
    chk("sleep_on_bit", 32'h1, q & 32'h1);
    sleep_req <= 1'b0;
    // RC conversion in sleep wakes when enabled
    w = wakes;
    go(8'h40, 8'hC1);
    sleep_req <= 1'b1;
    wait_done();
    idle(2);
    chk("wake", 32'(w + 1), 32'(wakes));
    sleep_req <= 1'b0;
    wr(ADDR_STATUS, 32'h1);
    go(8'h00, 8'hC1);
    sleep_req <= 1'b1;
    wait_done();
    idle(2);
    bus(ADDR_STATUS, 1'b0, 32'h0);
    chk("rc_off", 32'h2, q & 32'h2);
    bus(ADDR_CTRL_A, 1'b0, 32'h0);
    chk("rc_on_bit", 32'h1, q & 32'h1);
    chk("no_wake", 32'(w + 1), 32'(wakes));
    // Reset in mid conversion
    sleep_req <= 1'b0;
    go(8'h00, 8'h81);
    idle(50);
    hresetn <= 1'b0;
    idle(3);
    hresetn <= 1'b1;
    rd("rst_ctrl_a", ADDR_CTRL_A, {24'h000000, CTRL_A_RST});
    idle(500);
    chk("rst_flag", 32'h0, {31'h0, conversion_done_flag});
    rd("rst_status", ADDR_STATUS, 32'h0);
    rd("rst_hi", ADDR_RES_HI, 32'hFF);
    summarize();
  end
endmodule
